// ===== common/rtc_pkg.sv
// Constants, types and helpers for the serial real-time clock core
package rtc_pkg;

	localparam int          SYS_HZ        = 125_000_000;
	localparam int          XTAL_HZ       = 32_768;
	localparam int          XTAL_TICK_CYC = SYS_HZ / XTAL_HZ;
	localparam int          EXT_MAX_HZ    = 128_000;
	localparam int          DIV_W         = 15;
	localparam int          DIV_256HZ_BIT = 6;
	localparam int          DIV_32HZ_W    = 10;

	localparam logic [3:0]  ADDR_STATUS0  = 4'h0;
	localparam logic [3:0]  ADDR_STATUS1  = 4'h1;
	localparam logic [3:0]  ADDR_TIME_LO  = 4'h2;
	localparam logic [3:0]  ADDR_TIME_HI  = 4'h9;
	localparam logic [3:0]  LOAD_CMD      = 4'he;
	localparam logic [3:0]  SNAP_CMD      = 4'hf;
	localparam logic [7:0]  STATUS0_RST   = 8'h00;
	localparam logic [7:0]  STATUS1_RST   = 8'h00;

	localparam int          FREQ_BIT      = 0;
	localparam int          ACCEL_BIT     = 2;
	localparam int          PAR_BIT       = 3;
	localparam int          LOCK_BIT      = 4;

	localparam logic [3:0]  ADDR_BITS     = 4'd4;
	localparam logic [3:0]  LAST_BIT      = 4'd11;
	localparam int          N_LOC         = 8;

	// Seconds, minutes, hours, day, month, year, week day, week number
	localparam logic [7:0]  LOC_MIN [0:7] = '{8'h00, 8'h00, 8'h00, 8'h01,
	                                          8'h01, 8'h00, 8'h01, 8'h00};
	localparam logic [7:0]  LOC_MAX [0:7] = '{8'h59, 8'h59, 8'h23, 8'h31,
	                                          8'h12, 8'h99, 8'h07, 8'h52};

	typedef struct packed {
		logic valid;
		logic wr;
		logic din;
	} ser_bit_t;

	typedef enum logic [2:0] {
		MODE_NORMAL = 3'b001,
		MODE_ACCEL  = 3'b010,
		MODE_PAR    = 3'b100
	} tk_mode_t;

	// BCD increment; top bit flags the wrap back to the minimum
	function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo,
	                                       input logic [7:0] hi);
		logic [8:0] r;
		r = {1'b0, v};
		if (v >= hi || v < lo) begin
			r = {(v == hi), lo};
		end else if (v[3:0] >= 4'd9) begin
			r = {1'b0, v[7:4] + 4'd1, 4'd0};
		end else begin
			r = {1'b0, v[7:4], v[3:0] + 4'd1};
		end
		return r;
	endfunction

endpackage

// ===== src/rtc_core.sv
// Serial real-time clock core with frequency measurement and test modes
module rtc_core (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	// Serial access
	input  wire logic              cs_n,
	input  wire rtc_pkg::ser_bit_t ser_in,
	output logic                   io_out,
	output logic                   io_oe,
	// Oscillator source
	input  wire logic              ext_gen_sel,
	input  wire logic              ext_gen_tick,
	// Status
	output logic [7:0]             status0
);

	logic [11:0]           xtal_cnt_r;
	logic                  xtal_tick;
	logic                  osc_tick;
	logic [rtc_pkg::DIV_W-1:0] div_r;
	logic                  tick_1hz;
	logic                  tick_32hz;
	logic                  tk_tick;
	rtc_pkg::tk_mode_t     mode;

	logic [7:0]            ram_r [0:9];
	logic [7:0]            clk_r [0:7];
	logic [7:0]            clk_nxt [0:7];

	logic [3:0]            bit_cnt_r;
	logic [3:0]            addr_r;
	logic [7:0]            shift_r;
	logic                  bit_take;
	logic                  addr_phase;
	logic [3:0]            addr_full;
	logic                  addr_done;
	logic                  is_cmd;
	logic                  load_go;
	logic                  snap_go;
	logic                  byte_done;
	logic [7:0]            byte_in;
	logic                  addr_ok;
	logic [7:0]            rd_byte;
	logic                  freq_pulse;
	logic                  freq_drive;
	logic                  rd_drive;
	logic                  ram_wr;
	logic [7:0]            chg_flag;
	logic [11:0]           xtal_nxt;
	logic [rtc_pkg::DIV_W-1:0] div_nxt;

	// Crystal divider chain source: internal reference or external generator
	assign xtal_tick = (xtal_cnt_r == 12'(rtc_pkg::XTAL_TICK_CYC - 1));
	assign osc_tick  = ext_gen_sel ? ext_gen_tick : xtal_tick;
	assign xtal_nxt  = xtal_cnt_r + 12'h001;
	assign div_nxt   = div_r + 1'b1;

	always_ff @(posedge sys_clk) begin
		if (!rst_n || xtal_tick) begin
			xtal_cnt_r <= 12'h000;
		end else begin
			xtal_cnt_r <= xtal_nxt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			div_r <= '0;
		end else if (osc_tick) begin
			div_r <= div_nxt;
		end
	end

	assign tick_1hz   = osc_tick & (&div_r);
	assign tick_32hz  = osc_tick & (&div_r[rtc_pkg::DIV_32HZ_W-1:0]);
	assign freq_pulse = div_r[rtc_pkg::DIV_256HZ_BIT];

	// Test mode selection from control bits 2 and 3
	assign status0 = ram_r[rtc_pkg::ADDR_STATUS0];
	assign mode = status0[rtc_pkg::PAR_BIT]   ? rtc_pkg::MODE_PAR :
	              status0[rtc_pkg::ACCEL_BIT] ? rtc_pkg::MODE_ACCEL :
	              rtc_pkg::MODE_NORMAL;
	assign tk_tick = status0[rtc_pkg::ACCEL_BIT] ? tick_32hz : tick_1hz;

	// Serial bit decode
	assign bit_take   = ser_in.valid & ~cs_n;
	assign addr_phase = (bit_cnt_r < rtc_pkg::ADDR_BITS);
	assign addr_full  = {ser_in.din, addr_r[3:1]};
	assign addr_done  = bit_take & ser_in.wr & (bit_cnt_r == rtc_pkg::ADDR_BITS - 4'd1);
	assign is_cmd     = (addr_full == rtc_pkg::LOAD_CMD) || (addr_full == rtc_pkg::SNAP_CMD);
	assign load_go    = addr_done & (addr_full == rtc_pkg::LOAD_CMD)
	                    & ~status0[rtc_pkg::LOCK_BIT];
	assign snap_go    = addr_done & (addr_full == rtc_pkg::SNAP_CMD);
	assign byte_done  = bit_take & ser_in.wr & (bit_cnt_r == rtc_pkg::LAST_BIT);
	assign byte_in    = {ser_in.din, shift_r[7:1]};
	assign addr_ok    = (addr_r <= rtc_pkg::ADDR_TIME_HI);
	assign rd_byte    = (addr_full <= rtc_pkg::ADDR_TIME_HI) ? ram_r[addr_full] : 8'h00;

	// Pin drive: read data while selected, pulsed source only while deselected
	assign io_out = cs_n ? 1'b1 : shift_r[0];
	assign freq_drive = status0[rtc_pkg::FREQ_BIT] & freq_pulse;
	assign rd_drive   = ~ser_in.wr & ~addr_phase;
	assign io_oe      = cs_n ? freq_drive : rd_drive;
	assign ram_wr     = byte_done & addr_ok;

	// Bit counter and address/data shifter; no timeout between bits
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			bit_cnt_r <= 4'h0;
			addr_r    <= 4'h0;
			shift_r   <= 8'h00;
		end else if (bit_take) begin
			if (addr_phase) begin
				if (!ser_in.wr) begin
					bit_cnt_r <= 4'h0;
				end else if (addr_done) begin
					addr_r    <= addr_full;
					shift_r   <= rd_byte;
					bit_cnt_r <= is_cmd ? 4'h0 : rtc_pkg::ADDR_BITS;
				end else begin
					addr_r    <= addr_full;
					bit_cnt_r <= bit_cnt_r + 4'h1;
				end
			end else begin
				shift_r   <= ser_in.wr ? byte_in : {1'b0, shift_r[7:1]};
				bit_cnt_r <= (bit_cnt_r == rtc_pkg::LAST_BIT) ? 4'h0 : bit_cnt_r + 4'h1;
			end
		end
	end

	// Time keeping: carry chain, parallel increment, or load from RAM
	always_comb begin
		logic [8:0] inc;
		logic       c;
		inc = 9'h000;
		c   = tk_tick;
		for (int i = 0; i < rtc_pkg::N_LOC; i++) begin
			clk_nxt[i] = clk_r[i];
		end
		case (mode)
			rtc_pkg::MODE_PAR: begin
				if (tk_tick) begin
					for (int i = 0; i < rtc_pkg::N_LOC; i++) begin
						inc        = rtc_pkg::bcd_inc(clk_r[i], rtc_pkg::LOC_MIN[i],
						                              rtc_pkg::LOC_MAX[i]);
						clk_nxt[i] = inc[7:0];
					end
				end
			end
			default: begin
				for (int i = 0; i < 6; i++) begin
					if (c) begin
						inc        = rtc_pkg::bcd_inc(clk_r[i], rtc_pkg::LOC_MIN[i],
						                              rtc_pkg::LOC_MAX[i]);
						clk_nxt[i] = inc[7:0];
						c          = inc[8];
					end else begin
						c = 1'b0;
					end
					if (i == 2 && c) begin
						inc        = rtc_pkg::bcd_inc(clk_r[6], rtc_pkg::LOC_MIN[6],
						                              rtc_pkg::LOC_MAX[6]);
						clk_nxt[6] = inc[7:0];
						if (inc[8]) begin
							inc        = rtc_pkg::bcd_inc(clk_r[7], rtc_pkg::LOC_MIN[7],
							                              rtc_pkg::LOC_MAX[7]);
							clk_nxt[7] = inc[7:0];
						end
					end
				end
			end
		endcase
		if (load_go) begin
			for (int i = 0; i < rtc_pkg::N_LOC; i++) begin
				clk_nxt[i] = ram_r[i + 2];
			end
		end
	end

	// Clock locations, one register each, with snapshot change flags
	generate
		for (genvar g = 0; g < rtc_pkg::N_LOC; g++) begin : g_loc
			assign chg_flag[g] = (clk_r[g] != ram_r[g + 2]);
			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					clk_r[g] <= rtc_pkg::LOC_MIN[g];
				end else begin
					clk_r[g] <= clk_nxt[g];
				end
			end
		end
	endgenerate

	// RAM: serial writes, snapshot copy with change flags, load clears status 1
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < 10; i++) begin
				ram_r[i] <= 8'h00;
			end
			ram_r[rtc_pkg::ADDR_STATUS0] <= rtc_pkg::STATUS0_RST;
			ram_r[rtc_pkg::ADDR_STATUS1] <= rtc_pkg::STATUS1_RST;
		end else if (ram_wr) begin
			ram_r[addr_r] <= byte_in;
		end else if (snap_go) begin
			for (int i = 0; i < rtc_pkg::N_LOC; i++) begin
				ram_r[i + 2] <= clk_r[i];
			end
			ram_r[rtc_pkg::ADDR_STATUS1] <= chg_flag;
		end else if (load_go) begin
			ram_r[rtc_pkg::ADDR_STATUS1] <= 8'h00;
		end
	end

endmodule

// ===== dv/rtc_host_model.sv
// Host bus model driving the serial bit port of the clock core
module rtc_host_model (
	// Clock
	input  wire logic         sys_clk,
	// Pin from the core
	input  wire logic         io_out,
	input  wire logic         io_oe,
	// Serial access
	output logic              cs_n,
	output rtc_pkg::ser_bit_t ser_in
);
	timeunit 1ns;
	timeprecision 100ps;
	int gap = 0;
	// Released bus, pull-down holds the idle line
	wire pin = io_oe ? io_out : 1'b0;
	initial begin
		cs_n = 1'b1;
		ser_in = '0;
	end
	// One bit, taken on the next edge
	task automatic bit1(input logic w, input logic d, output logic q);
		repeat (gap) @(posedge sys_clk);
		@(posedge sys_clk) #1;
		cs_n = 1'b0;
		ser_in = '{1'b1, w, d};
		#2 q = pin;
		@(posedge sys_clk) #1;
		ser_in.valid = 1'b0;
	endtask
	task automatic cmd(input logic [3:0] c);
		logic q;
		for (int i = 0; i < 4; i++) bit1(1'b1, c[i], q);
	endtask
	task automatic xfer(input logic [3:0] a, input logic w, input logic [7:0] wd,
	                    output logic [7:0] rd);
		cmd(a);
		for (int i = 0; i < 8; i++) bit1(w, wd[i], rd[i]);
		@(posedge sys_clk) #1;
		cs_n = 1'b1;
		@(posedge sys_clk) #1;
	endtask
	task automatic snap_rd(input logic [3:0] a, output logic [7:0] d);
		cmd(rtc_pkg::SNAP_CMD);
		xfer(a, 1'b0, 8'h00, d);
	endtask
endmodule

// ===== dv/rtc_core_monitor.sv
// Port checker for the clock core
module rtc_core_monitor (
	// Clock and reset
	input wire logic              sys_clk,
	input wire logic              rst_n,
	// Watched ports
	input wire logic              cs_n,
	input wire rtc_pkg::ser_bit_t ser_in,
	input wire logic              io_out,
	input wire logic              io_oe,
	input wire logic              ext_gen_sel,
	input wire logic              ext_gen_tick,
	input wire logic [7:0]        status0
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	logic [3:0] cnt_r, cnt_nxt, adr_r, adr_nxt;
	wire take = !cs_n && ser_in.valid;
	wire [3:0] nib = {ser_in.din, adr_r[3:1]};
	wire wrap = (cnt_r == 4'h3 && nib >= 4'he) || cnt_r == 4'hb || (cnt_r < 4'h4 && !ser_in.wr);
	assign cnt_nxt = !take ? cnt_r : wrap ? 4'h0 : cnt_r + 4'h1;
	assign adr_nxt = take && cnt_r < 4'h4 ? nib : adr_r;
	always_ff @(posedge sys_clk) begin
		cnt_r <= rst_n ? cnt_nxt : 4'h0;
		adr_r <= rst_n ? adr_nxt : 4'h0;
	end
	quiet_idle_a: assert property (cs_n && !status0[0] |-> !io_oe)
		else $error("idle pin driven");
	idle_high_a: assert property (cs_n |-> io_out)
		else $error("idle level low");
	write_quiet_a: assert property (!cs_n && ser_in.wr |-> !io_oe)
		else $error("drive on write bit");
	pulse_cause_a: assert property (cs_n && $past(cs_n) && ext_gen_sel && $past(ext_gen_sel)
		&& $changed(io_oe) && $stable(status0) |-> $past(ext_gen_tick))
		else $error("pulse moved without tick");
	stat_cause_a: assert property ($changed(status0) |-> $past(ser_in.valid) && $past(ser_in.wr))
		else $error("status moved without write");
	stat_addr_a: assert property ($changed(status0) |-> $past(cnt_r) == 4'hb && $past(adr_r) == 4'h0)
		else $error("status write misplaced");
	out_hold_a: assert property (!cs_n && !$past(cs_n) && !$past(ser_in.valid) |-> $stable(io_out))
		else $error("read bit lost");
	data_phase_a: assert property (!cs_n && io_oe |-> cnt_r >= 4'h4)
		else $error("drive in address phase");
	cover property (cs_n && io_oe);
	cover property ($changed(status0));
	cover property (!cs_n && io_oe);
endmodule
bind rtc_core rtc_core_monitor mon (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n),
	.ser_in(ser_in), .io_out(io_out), .io_oe(io_oe), .ext_gen_sel(ext_gen_sel),
	.ext_gen_tick(ext_gen_tick), .status0(status0));

// ===== dv/rtc_test_and_freq_measure_tb.sv
// Self-checking bench for the clock test and measurement logic
module rtc_test_and_freq_measure_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 0, rst_n = 0, ext_gen_tick = 0, cs_n, io_out, io_oe;
	rtc_pkg::ser_bit_t ser_in;
	logic [7:0] status0, r;
	logic ext_gen_sel = 1'b1;
	int error_cnt = 0, cmp_count = 0;
	always #4 sys_clk = ~sys_clk;
	rtc_core uut (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n), .ser_in(ser_in),
		.io_out(io_out), .io_oe(io_oe), .ext_gen_sel(ext_gen_sel), .ext_gen_tick(ext_gen_tick),
		.status0(status0));
	rtc_host_model host (.sys_clk(sys_clk), .io_out(io_out), .io_oe(io_oe), .cs_n(cs_n),
		.ser_in(ser_in));
	task automatic check(string nm, logic [15:0] e, logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Generator ticks, one every two cycles; gap of last pulse edge pair
	task automatic ticks(int n, output int gap);
		int last;
		logic p;
		last = 0;
		p = io_oe;
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk) #1 ext_gen_tick = 1'b1;
			@(posedge sys_clk) #1 ext_gen_tick = 1'b0;
			if (io_oe !== p) begin
				gap = i - last;
				last = i;
			end
			p = io_oe;
		end
	endtask
	task automatic test_access();
		check("status0 reset", rtc_pkg::STATUS0_RST, status0);
		host.gap = 30;
		host.xfer(rtc_pkg::ADDR_STATUS0, 1'b1, 8'h10, r);
		host.gap = 0;
		check("status0 port", 8'h10, status0);
		host.xfer(rtc_pkg::ADDR_STATUS0, 1'b0, 8'h00, r);
		check("status0 read", 8'h10, r);
		$display("access test done");
	endtask
	task automatic test_freq();
		int g;
		host.xfer(rtc_pkg::ADDR_STATUS0, 1'b1, 8'h01, r);
		ticks(300, g);
		check("half period", 16'h0040, g);
		for (int i = 0; i < 70 && io_oe !== 1'b1; i++) ticks(1, g);
		check("pulse level", 1'b1, host.pin);
		host.cs_n = 1'b0;
		#1 check("selected drive", 1'b0, io_oe);
		host.cs_n = 1'b1;
		$display("frequency test done");
	endtask
	task automatic test_modes();
		logic [7:0] md [4] = '{8'h0c, 8'h04, 8'h08, 8'h00};
		logic [7:0] sd [4] = '{8'h03, 8'h03, 8'h00, 8'h00};
		logic [7:0] mn [4] = '{8'h03, 8'h00, 8'h00, 8'h00};
		logic [7:0] s0, m0, s1, m1;
		int g;
		foreach (md[k]) begin
			host.xfer(rtc_pkg::ADDR_STATUS0, 1'b1, md[k], r);
			host.snap_rd(4'h2, s0);
			host.snap_rd(4'h3, m0);
			ticks(3072, g);
			host.snap_rd(4'h2, s1);
			host.snap_rd(4'h3, m1);
			check("seconds step", s0 + sd[k], s1);
			check("minutes step", m0 + mn[k], m1);
		end
		host.xfer(4'h2, 1'b1, 8'h00, r);
		host.cmd(rtc_pkg::LOAD_CMD);
		host.snap_rd(4'h2, s1);
		check("reloaded seconds", 8'h00, s1);
		$display("mode test done");
	endtask
	initial begin
		repeat (5) @(posedge sys_clk);
		#1 rst_n = 1'b1;
		test_access();
		test_freq();
		test_modes();
		complete_run();
	end
	initial begin
		#400us;
		error_cnt++;
		complete_run();
	end
endmodule
